//--- design/sbs_pkg.sv
// constants shared by the stepper bridge sequencer
// assumes an 8-bit register port and a 250 MHz mclk
package sbs_pkg;
  // ==========================================
  // register port
  localparam int          AW = 4;
  localparam int          DW = 8;
  localparam logic [3:0]  ADDR_ARR   = 4'h0;
  localparam logic [3:0]  ADDR_CTRL  = 4'h1;
  localparam logic [3:0]  ADDR_LB    = 4'h2;
  localparam logic [3:0]  ADDR_OUTS  = 4'h3;
  localparam logic [3:0]  ADDR_PARA  = 4'h4;
  localparam logic [3:0]  ADDR_PARB  = 4'h5;
  localparam logic [3:0]  ADDR_POSU  = 4'h6;
  localparam logic [3:0]  ADDR_POSL  = 4'h7;
  localparam logic [3:0]  ADDR_SWRST = 4'h8;
  localparam logic [3:0]  ADDR_STAT  = 4'h9;
  localparam logic [3:0]  ADDR_GATES = 4'hA;
  // ==========================================
  // fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_DIR  = 1;
  localparam int CTRL_STB  = 2;
  localparam int LB_HS1A   = 0;
  localparam int LB_HS2A   = 1;
  localparam int PAR_P1    = 0;
  localparam int PAR_P2    = 1;
  localparam int SWRST_BIT = 0;
  localparam int TAG_LSB   = 5;
  localparam int O_HS1A    = 0;
  localparam int O_LS1A    = 1;
  localparam int O_HS1B    = 2;
  localparam int O_LS1B    = 3;
  localparam int O_HS2A    = 4;
  localparam int O_HS2B    = 5;
  localparam int O_LS2A    = 6;
  localparam int O_LS2B    = 7;
  // ==========================================
  // reset values and codes
  localparam logic [1:0]  ARR_HBRIDGE = 2'h0;
  localparam logic [1:0]  ARR_RST     = 2'h0;
  localparam logic [9:0]  CNT_RST     = 10'h200;
  localparam logic [9:0]  CNT_MAX     = 10'h3FF;
  localparam logic [9:0]  CNT_MIN     = 10'h000;
  localparam logic [1:0]  PHASE_RST   = 2'h0;
  // ==========================================
  // timing
  localparam int MCLK_MHZ           = 250;
  localparam int CRANK_HOLD_TIME_US = 100;
  localparam int CRANK_HOLD_CYC     = CRANK_HOLD_TIME_US * MCLK_MHZ;
  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b01,
    HOLD_RUN  = 2'b10
  } sbs_hold_t;
endpackage

//--- design/sbs_top.sv
// eight configurable power switches: two stepper H-bridges or
// eight independent stages, with crank hold and step position counter
// assumes a synchronous register master and synchronous pin inputs
`timescale 1ns/1ps
module sbs_top
  import sbs_pkg::*;
#(
  parameter int HOLD_CYC = sbs_pkg::CRANK_HOLD_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic [sbs_pkg::AW-1:0] addr,
  input  wire logic [sbs_pkg::DW-1:0] wdata,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic [sbs_pkg::DW-1:0]      rdata,
  input  wire logic                 mcu_reset_n,
  output logic                      hs1a,
  output logic                      ls1a,
  output logic                      hs1b,
  output logic                      ls1b,
  output logic                      hs2a,
  output logic                      hs2b,
  output logic                      ls2a,
  output logic                      ls2b
);
  import sbs_pkg::*;

  // ==========================================
  // decode
  logic        wr_arr;
  logic        wr_ctrl;
  logic        wr_lb;
  logic        wr_outs;
  logic        wr_para;
  logic        wr_parb;
  logic        wr_swrst;
  assign wr_arr   = wr_en && (addr == ADDR_ARR);
  assign wr_ctrl  = wr_en && (addr == ADDR_CTRL);
  assign wr_lb    = wr_en && (addr == ADDR_LB);
  assign wr_outs  = wr_en && (addr == ADDR_OUTS);
  assign wr_para  = wr_en && (addr == ADDR_PARA);
  assign wr_parb  = wr_en && (addr == ADDR_PARB);
  assign wr_swrst = wr_en && (addr == ADDR_SWRST) && wdata[SWRST_BIT];

  // ==========================================
  // configuration
  logic [1:0]  arr_r;
  logic [1:0]  lb_r;
  logic [1:0]  para_r;
  logic [1:0]  parb_r;
  logic        hbridge_mode;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      arr_r <= ARR_RST;
    end else if (wr_arr) begin
      arr_r <= wdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lb_r <= 2'h0;
    end else if (wr_lb) begin
      lb_r <= {wdata[LB_HS2A], wdata[LB_HS1A]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      para_r <= 2'h0;
      parb_r <= 2'h0;
    end else begin
      if (wr_para) begin
        para_r <= wdata[1:0];
      end
      if (wr_parb) begin
        parb_r <= wdata[1:0];
      end
    end
  end

  assign hbridge_mode = (arr_r == ARR_HBRIDGE) && (lb_r == 2'h0);

  // ==========================================
  // enable, direction and strobe
  logic        en_r;
  logic        dir_r;
  logic        stb_r;
  logic        stb_rise;
  logic        en_chg;
  logic        take_step;
  assign stb_rise = wr_ctrl && wdata[CTRL_STB] && !stb_r;
  assign en_chg   = wr_ctrl && (wdata[CTRL_EN] != en_r);
  // an enable change swallows the strobe
  assign take_step = stb_rise && en_r && !en_chg && hbridge_mode;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      en_r  <= 1'b0;
      dir_r <= 1'b0;
      stb_r <= 1'b0;
    end else if (wr_ctrl) begin
      en_r  <= wdata[CTRL_EN];
      dir_r <= wdata[CTRL_DIR];
      stb_r <= wdata[CTRL_STB];
    end
  end

  // ==========================================
  // step phase
  logic [1:0]  phase_r;

  // advance with the direction held before this write
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase_r <= PHASE_RST;
    end else if (take_step) begin
      phase_r <= dir_r ? phase_r + 2'h1 : phase_r - 2'h1;
    end
  end

  // ==========================================
  // position counter
  logic [9:0]  cnt_r;
  logic [1:0]  tag_r;

  always_ff @(posedge mclk) begin
    if (!rstn || wr_swrst) begin
      cnt_r <= CNT_RST;
    end else if (take_step) begin
      if (dir_r && cnt_r != CNT_MAX) begin
        cnt_r <= cnt_r + 10'h001;
      end else if (!dir_r && cnt_r != CNT_MIN) begin
        cnt_r <= cnt_r - 10'h001;
      end
    end
  end

  // check bits tick on every step, shown in both halves
  always_ff @(posedge mclk) begin
    if (!rstn || wr_swrst) begin
      tag_r <= 2'h0;
    end else if (take_step) begin
      tag_r <= tag_r + 2'h1;
    end
  end

  // ==========================================
  // independent commands and crank hold
  logic [7:0]  outs_r;
  logic        mcu_q;
  logic        mcu_fall;
  logic        mcu_in_rst_r;
  sbs_hold_t   hold_r;
  logic [31:0] hold_cnt_r;
  logic        hold_end;
  assign mcu_fall = mcu_q && !mcu_reset_n;
  assign hold_end = (hold_r == HOLD_RUN) && (hold_cnt_r == 32'(HOLD_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mcu_q        <= 1'b1;
      mcu_in_rst_r <= 1'b0;
    end else begin
      mcu_q <= mcu_reset_n;
      if (mcu_fall) begin
        mcu_in_rst_r <= 1'b1;
      end else if (mcu_reset_n) begin
        mcu_in_rst_r <= 1'b0;
      end
    end
  end

  // hold timer from the reset pin falling edge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hold_r     <= HOLD_IDLE;
      hold_cnt_r <= 32'h0;
    end else begin
      unique case (hold_r)
        HOLD_IDLE: begin
          hold_cnt_r <= 32'h0;
          if (mcu_fall && lb_r != 2'h0) begin
            hold_r <= HOLD_RUN;
          end
        end
        HOLD_RUN: begin
          hold_cnt_r <= hold_cnt_r + 32'h1;
          // a command write means the controller is back in charge
          if (wr_outs || hold_end) begin
            hold_r <= HOLD_IDLE;
          end
        end
        default: begin
          hold_r <= HOLD_IDLE;
        end
      endcase
    end
  end

  // expiry drops the held high sides
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      outs_r <= 8'h00;
    end else if (wr_outs) begin
      outs_r <= wdata;
    end else if (hold_end) begin
      outs_r[O_HS1A] <= 1'b0;
      outs_r[O_HS2A] <= 1'b0;
    end
  end

  // ==========================================
  // gate composition
  logic [7:0]  br;
  logic [7:0]  br_safe;
  logic [7:0]  ind;
  logic [7:0]  gate_nxt;
  logic [7:0]  gate_r;

  always_comb begin
    br = 8'h00;
    if (en_r) begin
      unique case (phase_r)
        2'h0: br = 8'(1 << O_HS1A) | 8'(1 << O_LS1B) | 8'(1 << O_HS2B) | 8'(1 << O_LS2A);
        2'h1: br = 8'(1 << O_HS1A) | 8'(1 << O_LS1B) | 8'(1 << O_HS2A) | 8'(1 << O_LS2B);
        2'h2: br = 8'(1 << O_HS1B) | 8'(1 << O_LS1A) | 8'(1 << O_HS2A) | 8'(1 << O_LS2B);
        2'h3: br = 8'(1 << O_HS1B) | 8'(1 << O_LS1A) | 8'(1 << O_HS2B) | 8'(1 << O_LS2A);
      endcase
    end
  end

  // high side wins any clash within a half-bridge
  always_comb begin
    br_safe         = br;
    br_safe[O_LS1A] = br[O_LS1A] && !br[O_HS1A];
    br_safe[O_LS1B] = br[O_LS1B] && !br[O_HS1B];
    br_safe[O_LS2A] = br[O_LS2A] && !br[O_HS2A];
    br_safe[O_LS2B] = br[O_LS2B] && !br[O_HS2B];
  end

  // paired stages copy their partner, no coherency check
  always_comb begin
    ind         = outs_r;
    ind[O_LS1B] = para_r[PAR_P1] ? outs_r[O_LS1A] : outs_r[O_LS1B];
    ind[O_LS2B] = para_r[PAR_P2] ? outs_r[O_LS2A] : outs_r[O_LS2B];
    ind[O_HS1B] = parb_r[PAR_P1] ? outs_r[O_HS1A] : outs_r[O_HS1B];
    ind[O_HS2B] = parb_r[PAR_P2] ? outs_r[O_HS2A] : outs_r[O_HS2B];
    // with the controller in reset only held high sides stay on
    if (mcu_in_rst_r) begin
      ind         = 8'h00;
      ind[O_HS1A] = (hold_r == HOLD_RUN) && lb_r[LB_HS1A] && outs_r[O_HS1A];
      ind[O_HS2A] = (hold_r == HOLD_RUN) && lb_r[LB_HS2A] && outs_r[O_HS2A];
    end
  end

  assign gate_nxt = hbridge_mode ? br_safe : ind;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      gate_r <= 8'h00;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  assign hs1a = gate_r[O_HS1A];
  assign ls1a = gate_r[O_LS1A];
  assign hs1b = gate_r[O_HS1B];
  assign ls1b = gate_r[O_LS1B];
  assign hs2a = gate_r[O_HS2A];
  assign hs2b = gate_r[O_HS2B];
  assign ls2a = gate_r[O_LS2A];
  assign ls2b = gate_r[O_LS2B];

  // ==========================================
  // readback, one cycle after the strobe
  logic [7:0]  rd_nxt;

  always_comb begin
    rd_nxt = 8'h00;
    unique case (addr)
      ADDR_ARR:   rd_nxt = {6'h00, arr_r};
      ADDR_CTRL:  rd_nxt = {5'h00, stb_r, dir_r, en_r};
      ADDR_LB:    rd_nxt = {6'h00, lb_r};
      ADDR_OUTS:  rd_nxt = outs_r;
      ADDR_PARA:  rd_nxt = {6'h00, para_r};
      ADDR_PARB:  rd_nxt = {6'h00, parb_r};
      ADDR_POSU:  rd_nxt = {1'b0, tag_r, cnt_r[9:5]};
      ADDR_POSL:  rd_nxt = {1'b0, tag_r, cnt_r[4:0]};
      ADDR_STAT:  rd_nxt = {3'h0, hold_r == HOLD_RUN, mcu_in_rst_r, hbridge_mode, phase_r};
      ADDR_GATES: rd_nxt = gate_r;
      default:    rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= rd_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_fwd_step;
    take_step && dir_r;
  endsequence
  sequence s_rev_step;
    take_step && !dir_r;
  endsequence
  sequence s_dir_flip_rise;
    stb_rise && en_r && !en_chg && hbridge_mode && (wdata[CTRL_DIR] != dir_r);
  endsequence

  interlock_hb_a: assert property (hbridge_mode |-> ##1
    !(gate_r[O_HS1A] && gate_r[O_LS1A]) && !(gate_r[O_HS1B] && gate_r[O_LS1B]) &&
    !(gate_r[O_HS2A] && gate_r[O_LS2A]) && !(gate_r[O_HS2B] && gate_r[O_LS2B]))
    else $error("half-bridge shoot-through");
  enable_off_a: assert property (hbridge_mode && !en_r |=> gate_r == 8'h00)
    else $error("bridge conducts with enable low");
  step_fwd_a: assert property (s_fwd_step |=> phase_r == $past(phase_r) + 2'h1)
    else $error("forward step wrong phase");
  step_rev_a: assert property (s_rev_step |=> phase_r == $past(phase_r) - 2'h1)
    else $error("reverse step wrong phase");
  old_dir_a: assert property (s_dir_flip_rise ##1 1'b1 |->
    (phase_r == ($past(dir_r) ? $past(phase_r) + 2'h1 : $past(phase_r) - 2'h1)))
    else $error("step did not use previous direction");
  en_wins_a: assert property (stb_rise && en_chg |=> $stable(phase_r) && $stable(cnt_r))
    else $error("strobe acted beside enable change");
  cnt_only_a: assert property (!take_step && !wr_swrst |=> $stable(cnt_r))
    else $error("position moved without a step");
  cnt_sat_a: assert property (take_step && dir_r && cnt_r == CNT_MAX |=> cnt_r == CNT_MAX)
    else $error("position wrapped at top");
  cnt_up_a: assert property (take_step && dir_r && cnt_r != CNT_MAX
    |=> cnt_r == $past(cnt_r) + 10'h001)
    else $error("position did not count up");
  cnt_swrst_a: assert property (wr_swrst |=> cnt_r == CNT_RST && tag_r == 2'h0)
    else $error("software reset missed position");
  lb_force_a: assert property (lb_r != 2'h0 && para_r == 2'h0 && parb_r == 2'h0
    && !mcu_in_rst_r |=> gate_r == $past(outs_r))
    else $error("hold enable did not force stages");
  hold_expire_a: assert property (hold_end && !wr_outs |=>
    !outs_r[O_HS1A] && !outs_r[O_HS2A] && hold_r == HOLD_IDLE)
    else $error("hold did not end at its time");
endmodule

//--- sim/sbs_mcu_model.sv
// register-port master standing in for the engine controller
// assumes the sequencer samples strobes on rising mclk
`timescale 1ns/1ps
module sbs_mcu_model (
  input  wire logic                   mclk,
  input  wire logic [sbs_pkg::DW-1:0] rdata,
  output logic [sbs_pkg::AW-1:0]      addr,
  output logic [sbs_pkg::DW-1:0]      wdata,
  output logic                        wr_en,
  output logic                        rd_en,
  output logic                        mcu_reset_n
);
  import sbs_pkg::*;
  initial begin
    addr        = '0;
    wdata       = '0;
    wr_en       = 1'h0;
    rd_en       = 1'h0;
    mcu_reset_n = 1'h1;
  end
  // ==========================================
  // bus cycles, one frame each
  // released lines flip so a stale value never passes for a live one
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge mclk);
    wr_en <= 1'h0;
    addr  <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'h1;
    @(posedge mclk);
    rd_en <= 1'h0;
    addr  <= ~a;
    #1 d = rdata;
  endtask
  task automatic pin(input logic lvl);
    @(posedge mclk);
    mcu_reset_n <= lvl;
  endtask
endmodule

//--- sim/sbs_tb_top.sv
// self-checking bench for the stepper bridge sequencer
// assumes the register master model drives every bus input
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
      $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
      num_errors++; \
    end \
  end
module sbs_tb_top;
  import sbs_pkg::*;
  localparam int HC = 20;
  logic          mclk = 1'h0;
  logic          rstn = 1'h0;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic          wr_en, rd_en, mcu_reset_n;
  logic          hs1a, ls1a, hs1b, ls1b, hs2a, hs2b, ls2a, ls2b;
  logic [7:0]    gates, v;
  logic [9:0]    cnt = CNT_RST;
  logic [1:0]    ph = PHASE_RST;
  logic [1:0]    tg = 2'h0;
  logic [31:0]   seed = 32'h79B7;
  int            num_errors = 0;
  int            total_checks = 0;
  assign gates = {ls2b, ls2a, hs2b, hs2a, ls1b, hs1b, ls1a, hs1a};
  always #2 mclk = ~mclk;
  sbs_top #(.HOLD_CYC(HC)) dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .mcu_reset_n(mcu_reset_n), .hs1a(hs1a),
    .ls1a(ls1a), .hs1b(hs1b), .ls1b(ls1b), .hs2a(hs2a), .hs2b(hs2b), .ls2a(ls2a),
    .ls2b(ls2b));
  sbs_mcu_model mcu_u (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .mcu_reset_n(mcu_reset_n));
  // ==========================================
  // expectations
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ph_gates(input logic [1:0] p);
    case (p)
      2'h0: return 8'h69;
      2'h1: return 8'h99;
      2'h2: return 8'h96;
      default: return 8'h66;
    endcase
  endfunction
  task automatic model(input logic d);
    ph = d ? ph + 2'h1 : ph - 2'h1;
    // check bits tick on every step taken, saturated or not
    tg = tg + 2'h1;
    if (d && cnt != CNT_MAX) cnt = cnt + 10'h1;
    else if (!d && cnt != CNT_MIN) cnt = cnt - 10'h1;
  endtask
  // ==========================================
  // stimulus and checks
  task automatic step(input logic d);
    mcu_u.wr(ADDR_CTRL, {6'h0, d, 1'h1});
    mcu_u.wr(ADDR_CTRL, {5'h0, 1'h1, d, 1'h1});
    model(d);
  endtask
  task automatic chk_g(input logic [7:0] e);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("gates", e, gates)
  endtask
  task automatic chk_pos();
    logic [7:0] u, l;
    mcu_u.rd(ADDR_POSU, u);
    mcu_u.rd(ADDR_POSL, l);
    `CHK("position", cnt, {u[4:0], l[4:0]})
    `CHK("upper check bits", tg, u[6:5])
    `CHK("lower check bits", tg, l[6:5])
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'h1;
    chk_g(8'h00);
    mcu_u.rd(ADDR_ARR, v);
    `CHK("arrangement", ARR_HBRIDGE, v[1:0])
    chk_pos();
    // enable with a strobe in the same frame: no step
    mcu_u.wr(ADDR_CTRL, 8'h05);
    chk_g(8'h69);
    chk_pos();
    step(1'h1);
    chk_g(ph_gates(ph));
    chk_pos();
    // new direction beside the strobe still steps the old way
    mcu_u.wr(ADDR_CTRL, 8'h01);
    mcu_u.wr(ADDR_CTRL, 8'h07);
    model(1'h0);
    chk_g(ph_gates(ph));
    chk_pos();
    mcu_u.wr(ADDR_CTRL, 8'h03);
    chk_g(ph_gates(ph));
    repeat (150) begin
      v = 8'(xs());
      step(v[0]);
      chk_g(ph_gates(ph));
      chk_pos();
    end
    while (cnt != CNT_MAX) step(1'h1);
    repeat (2) step(1'h1);
    chk_pos();
    step(1'h0);
    chk_pos();
    while (cnt != CNT_MIN) step(1'h0);
    repeat (2) step(1'h0);
    chk_pos();
    chk_g(ph_gates(ph));
    // rise with enable low, and writes to read-only or unmapped places
    mcu_u.wr(ADDR_CTRL, 8'h00);
    chk_g(8'h00);
    mcu_u.wr(ADDR_CTRL, 8'h04);
    mcu_u.wr(ADDR_POSU, 8'hFF);
    mcu_u.wr(4'hF, 8'hFF);
    chk_pos();
    mcu_u.wr(ADDR_CTRL, 8'h00);
    mcu_u.wr(ADDR_CTRL, 8'h01);
    chk_g(ph_gates(ph));
    step(1'h1);
    mcu_u.wr(ADDR_SWRST, 8'h01);
    cnt = CNT_RST;
    tg = 2'h0;
    chk_pos();
    mcu_u.wr(ADDR_ARR, 8'h01);
    repeat (4) begin
      v = 8'(xs());
      mcu_u.wr(ADDR_OUTS, v);
      chk_g(v);
    end
    // steps are ignored while the stages are independent
    mcu_u.wr(ADDR_CTRL, 8'h01);
    mcu_u.wr(ADDR_CTRL, 8'h05);
    chk_pos();
    mcu_u.wr(ADDR_PARA, 8'h03);
    mcu_u.wr(ADDR_OUTS, 8'h42);
    chk_g(8'hCA);
    mcu_u.wr(ADDR_PARB, 8'h03);
    mcu_u.wr(ADDR_OUTS, 8'h11);
    chk_g(8'h35);
    mcu_u.wr(ADDR_PARA, 8'h00);
    mcu_u.wr(ADDR_PARB, 8'h00);
    mcu_u.wr(ADDR_ARR, 8'h00);
    chk_g(ph_gates(ph));
    mcu_u.wr(ADDR_LB, 8'h01);
    chk_g(8'h11);
    // crank dip: only the enabled output is held, then times out
    mcu_u.pin(1'h0);
    repeat (5) @(posedge mclk);
    #1;
    `CHK("held gates", 8'h01, gates)
    repeat (HC + 5) @(posedge mclk);
    #1;
    `CHK("expired gates", 8'h00, gates)
    mcu_u.pin(1'h1);
    mcu_u.pin(1'h0);
    repeat (3) @(posedge mclk);
    mcu_u.pin(1'h1);
    mcu_u.wr(ADDR_OUTS, 8'h11);
    repeat (HC + 5) @(posedge mclk);
    #1;
    `CHK("resumed gates", 8'h11, gates)
    give_verdict();
  end
endmodule
